// *** core/mims_map.svh ***
// Register offsets, field positions and reset values of the monitor interrupt mask and status block.
// Assumes inclusion by bare name from core/ sources; definitions only.
//
// Overview of operation
// - The thermal alert mode bit selects default behaviour of the thermal alert output at 0 and ACPI-style at 1.
// - With enable bit 6 set, the third VID line acts as an active-high external interrupt input when globally enabled.
// - With enable bit 7 set, the fourth VID line acts as an active-high external interrupt input when globally enabled.
// - The per-line VID interrupt enables act only while the global enable in bit 7 of the channel mode register is set.
// - Writing 1 to bit 7 of the configuration register at 40h reinitialises the chip and frees the once-type lock.
// - Status mirror bit 0 (2.5 V rail) and bit 1 (first core rail) read 1 whenever that input is past a limit.
`ifndef MIMS_MAP_SVH
`define MIMS_MAP_SVH

`define MIMS_ADDR_CONFIG_ONE 8'h40
`define MIMS_ADDR_MASK_CFG 8'h44
`define MIMS_ADDR_STATUS_MIRROR 8'h4C
`define MIMS_BIT_REINIT 7
`define MIMS_BIT_GLOBAL_EN 7
`define MIMS_BIT_ONCE 2
`define MIMS_BIT_THERMAL_ALERT_PIN_MODE 3
`define MIMS_BIT_IRQ3_EN 6
`define MIMS_BIT_IRQ4_EN 7
`define MIMS_BIT_RAIL25 0
`define MIMS_BIT_CORE1 1
`define MIMS_RESET_BYTE 8'h00
`define MIMS_MASK_CFG_WMASK 8'hCF

`endif

// *** core/mims_pkg.sv ***
// Types shared by the monitor interrupt mask and status block.
// Assumes the map header for all numbers.
package mims_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mims_req_type;

    typedef struct packed {
        logic alert_acpi;
        logic irq3_live;
        logic irq4_live;
    } mims_cfg_type;
endpackage

// *** core/mims_status_mirror.sv ***
// Read-only mirror of the first interrupt status register.
// Assumes limit flags arrive synchronous to clk_sys from the comparison logic.
`timescale 1ns/1ps
`include "mims_map.svh"
module mims_status_mirror (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Live status from the monitor
    input wire logic [7:0] status_live,
    // Mirror value
    output logic [7:0] mirror
);
    logic [7:0] next_mirror;

    // Mirror only follows the status; no access path can clear it
    always_comb begin
        next_mirror = status_live;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mirror <= `MIMS_RESET_BYTE;
        end else begin
            mirror <= next_mirror;
        end
    end

    a_mirror_follows_rail: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 mirror[`MIMS_BIT_RAIL25] == $past(status_live[`MIMS_BIT_RAIL25]))
        else $error("Rail status bit not mirrored");
endmodule

// *** core/mims_top.sv ***
// Interrupt mask/alert configuration and status mirror block of a hardware monitor.
// Assumes a serial bus engine hands over single-cycle byte accesses synchronous to clk_sys.
`timescale 1ns/1ps
`include "mims_map.svh"
module mims_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register access from the serial bus engine
    input wire mims_pkg::mims_req_type req,
    output logic [7:0] rdata,
    // Live status flags from the limit comparators
    input wire logic [7:0] status_live,
    // Global enable from the channel mode register
    input wire logic [7:0] chan_mode,
    // VID lines
    input wire logic vid_line_three_irq,
    input wire logic vid_line_four_irq,
    // Configuration outputs
    output mims_pkg::mims_cfg_type cfg,
    output logic ext_irq_event,
    output logic reinit_pulse
);
    ////////////////////////////////////////////////////////////////
    logic [7:0] mask_cfg;
    logic [7:0] next_mask_cfg;
    logic reinit;
    logic next_reinit;
    logic reinit_write;
    logic [7:0] mirror;
    logic [7:0] next_rdata;
    logic next_ext_irq_event;
    logic external_irq_global_enable;
    mims_pkg::mims_cfg_type next_cfg;

    function automatic logic hit(input mims_pkg::mims_req_type r, input logic [7:0] a);
        hit = r.addr == a;
    endfunction

    assign external_irq_global_enable = chan_mode[`MIMS_BIT_GLOBAL_EN];

    // Decoded once so the write path and its checks cannot drift apart
    assign reinit_write = req.wr && hit(req, `MIMS_ADDR_CONFIG_ONE) && req.wdata[`MIMS_BIT_REINIT];

    mims_status_mirror u_mirror (
        .clk_sys(clk_sys),
        .srst(srst),
        .status_live(status_live),
        .mirror(mirror)
    );

    ////////////////////////////////////////////////////////////////
    // Register writes; reserved bits 4-5 stay zero
    always_comb begin
        next_mask_cfg = mask_cfg;
        next_reinit = 1'b0;
        if (req.wr && hit(req, `MIMS_ADDR_MASK_CFG)) begin
            next_mask_cfg = (mask_cfg & ~`MIMS_MASK_CFG_WMASK) | (req.wdata & `MIMS_MASK_CFG_WMASK);
            // Once bit only sets; it stays until reset or reinitialise
            next_mask_cfg[`MIMS_BIT_ONCE] = mask_cfg[`MIMS_BIT_ONCE] | req.wdata[`MIMS_BIT_ONCE];
        end
        if (reinit_write) begin
            next_reinit = 1'b1;
            next_mask_cfg = `MIMS_RESET_BYTE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mask_cfg <= `MIMS_RESET_BYTE;
            reinit <= 1'b0;
        end else begin
            mask_cfg <= next_mask_cfg;
            reinit <= next_reinit;
        end
    end

    assign reinit_pulse = reinit;

    ////////////////////////////////////////////////////////////////
    // Alert mode and external interrupt qualification
    always_comb begin
        next_cfg.alert_acpi = mask_cfg[`MIMS_BIT_THERMAL_ALERT_PIN_MODE];
        next_cfg.irq3_live = mask_cfg[`MIMS_BIT_IRQ3_EN] & external_irq_global_enable;
        next_cfg.irq4_live = mask_cfg[`MIMS_BIT_IRQ4_EN] & external_irq_global_enable;
        next_ext_irq_event = (next_cfg.irq3_live & vid_line_three_irq)
            | (next_cfg.irq4_live & vid_line_four_irq);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg <= '0;
            ext_irq_event <= 1'b0;
        end else begin
            cfg <= next_cfg;
            ext_irq_event <= next_ext_irq_event;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data; the mirror read has no side effect
    always_comb begin
        next_rdata = 8'h00;
        if (req.rd) begin
            if (hit(req, `MIMS_ADDR_MASK_CFG)) begin
                next_rdata = mask_cfg;
            end else if (hit(req, `MIMS_ADDR_STATUS_MIRROR)) begin
                next_rdata = mirror;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Access steps named once for the checks below
    sequence s_reinit_write;
        reinit_write;
    endsequence
    sequence s_mask_write;
        req.wr && hit(req, `MIMS_ADDR_MASK_CFG);
    endsequence
    sequence s_mask_read;
        req.rd && hit(req, `MIMS_ADDR_MASK_CFG);
    endsequence

    sequence s_mirror_read;
        req.rd && hit(req, `MIMS_ADDR_STATUS_MIRROR);
    endsequence
    sequence s_mirror_write;
        req.wr && hit(req, `MIMS_ADDR_STATUS_MIRROR);
    endsequence

    // Status has to pass the mirror flop before a read can return it
    sequence s_core_then_read;
        status_live[`MIMS_BIT_CORE1] ##1 s_mirror_read;
    endsequence
    sequence s_core_clear_then_read;
        !status_live[`MIMS_BIT_CORE1] ##1 s_mirror_read;
    endsequence
    sequence s_rail_then_read;
        status_live[`MIMS_BIT_RAIL25] ##1 s_mirror_read;
    endsequence
    sequence s_rail_clear_then_read;
        !status_live[`MIMS_BIT_RAIL25] ##1 s_mirror_read;
    endsequence

    ////////////////////////////////////////////////////////////////
    // Alert mode and interrupt gating
    a_alert_mode: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 cfg.alert_acpi == $past(mask_cfg[`MIMS_BIT_THERMAL_ALERT_PIN_MODE]))
        else $error("Alert mode does not follow config bit");
    a_alert_write_lands: assert property (@(posedge clk_sys) disable iff (srst)
        s_mask_write |=> mask_cfg[`MIMS_BIT_THERMAL_ALERT_PIN_MODE] == $past(req.wdata[`MIMS_BIT_THERMAL_ALERT_PIN_MODE]))
        else $error("Alert mode bit not written");
    a_irq3_gate: assert property (@(posedge clk_sys) disable iff (srst)
        (mask_cfg[`MIMS_BIT_IRQ3_EN] && vid_line_three_irq && external_irq_global_enable) |=> ext_irq_event)
        else $error("Third VID interrupt not raised");
    a_irq3_live: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 cfg.irq3_live == ($past(mask_cfg[`MIMS_BIT_IRQ3_EN]) && $past(external_irq_global_enable)))
        else $error("Third VID enable not qualified");
    a_irq4_gate: assert property (@(posedge clk_sys) disable iff (srst)
        (mask_cfg[`MIMS_BIT_IRQ4_EN] && vid_line_four_irq && external_irq_global_enable) |=> ext_irq_event)
        else $error("Fourth VID interrupt not raised");
    a_irq4_live: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 cfg.irq4_live == ($past(mask_cfg[`MIMS_BIT_IRQ4_EN]) && $past(external_irq_global_enable)))
        else $error("Fourth VID enable not qualified");
    // Lines whose enable is clear may toggle freely without effect
    a_vid_quiet: assert property (@(posedge clk_sys) disable iff (srst)
        (!(mask_cfg[`MIMS_BIT_IRQ3_EN] && vid_line_three_irq)
        && !(mask_cfg[`MIMS_BIT_IRQ4_EN] && vid_line_four_irq)) |=> !ext_irq_event)
        else $error("Interrupt raised by a disabled VID line");
    a_global_gate: assert property (@(posedge clk_sys) disable iff (srst)
        !external_irq_global_enable |=> !ext_irq_event)
        else $error("Interrupt raised without global enable");
    a_global_cfg_off: assert property (@(posedge clk_sys) disable iff (srst)
        !external_irq_global_enable |=> (!cfg.irq3_live && !cfg.irq4_live))
        else $error("VID enable live without global enable");

    ////////////////////////////////////////////////////////////////
    // Reinitialise and the once lock
    a_reinit_clears: assert property (@(posedge clk_sys) disable iff (srst)
        s_reinit_write |=> (reinit_pulse && mask_cfg == `MIMS_RESET_BYTE))
        else $error("Reinitialise did not clear config");
    a_reinit_settles: assert property (@(posedge clk_sys) disable iff (srst)
        s_reinit_write |=> ##1 (cfg == '0 && !ext_irq_event))
        else $error("Config outputs not cleared after reinitialise");
    a_reinit_only_write: assert property (@(posedge clk_sys) disable iff (srst)
        !reinit_write |=> !reinit_pulse)
        else $error("Reinitialise pulse without a write");
    a_once_lock_holds: assert property (@(posedge clk_sys) disable iff (srst)
        (mask_cfg[`MIMS_BIT_ONCE] && !reinit_write) |=> mask_cfg[`MIMS_BIT_ONCE])
        else $error("Once bit released without reinitialise");

    ////////////////////////////////////////////////////////////////
    // Read path; reads must leave every register as it was
    a_core_mirror: assert property (@(posedge clk_sys) disable iff (srst)
        s_core_then_read |=> rdata[`MIMS_BIT_CORE1])
        else $error("Core rail status not read back");
    a_core_clear: assert property (@(posedge clk_sys) disable iff (srst)
        s_core_clear_then_read |=> !rdata[`MIMS_BIT_CORE1])
        else $error("Core rail status read without a limit event");
    a_rail_mirror: assert property (@(posedge clk_sys) disable iff (srst)
        s_rail_then_read |=> rdata[`MIMS_BIT_RAIL25])
        else $error("Rail status not read back");
    a_rail_clear: assert property (@(posedge clk_sys) disable iff (srst)
        s_rail_clear_then_read |=> !rdata[`MIMS_BIT_RAIL25])
        else $error("Rail status read without a limit event");
    a_mirror_read_data: assert property (@(posedge clk_sys) disable iff (srst)
        s_mirror_read |=> rdata == $past(mirror))
        else $error("Mirror read returned other data");
    a_mirror_read_clean: assert property (@(posedge clk_sys) disable iff (srst)
        s_mirror_read |=> mirror == $past(status_live))
        else $error("Mirror read disturbed the mirror");
    a_mirror_no_write: assert property (@(posedge clk_sys) disable iff (srst)
        s_mirror_write |=> $stable(mask_cfg))
        else $error("Mirror write changed state");
    a_mask_read_back: assert property (@(posedge clk_sys) disable iff (srst)
        s_mask_read |=> rdata == $past(mask_cfg))
        else $error("Config read returned other data");
    a_idle_read_zero: assert property (@(posedge clk_sys) disable iff (srst)
        !req.rd |=> rdata == 8'h00)
        else $error("Read data present without a read");
endmodule

// *** verif/mims_host_model.sv ***
// Host side of the register path: issues single byte accesses.
// Assumes the design samples requests on the rising edge of clk_sys.
`timescale 1ns/1ps
module mims_host_model (
    // Clock
    input wire logic clk_sys,
    // Register access
    output mims_pkg::mims_req_type req,
    input wire logic [7:0] rdata
);
    initial req = '0;
    // Released lines show inverted values so a stale address cannot pass
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] data);
        @(negedge clk_sys);
        req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        data = rdata;
    endtask
endmodule

// *** verif/mims_top_tb_top.sv ***
// Self-checking bench for the interrupt mask and status mirror block.
// Assumes the host model drives all register traffic.
`timescale 1ns/1ps
module mims_top_tb_top;
    typedef struct {logic [7:0] mask; logic [7:0] mode; logic v3; logic v4; logic [7:0] cfg; logic irq;} mims_row_type;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] status_live = 8'h00;
    logic [7:0] chan_mode = 8'h00;
    logic vid_line_three_irq = 1'b0;
    logic vid_line_four_irq = 1'b0;
    mims_pkg::mims_req_type req;
    mims_pkg::mims_cfg_type cfg;
    logic [7:0] rdata;
    logic [7:0] rd_val;
    logic ext_irq_event;
    logic reinit_pulse;
    int err_count = 0;
    int checks = 0;
    mims_row_type rows [6] = '{
        '{8'h08, 8'h00, 1'b1, 1'b1, 8'h04, 1'b0}, '{8'h00, 8'h80, 1'b1, 1'b1, 8'h00, 1'b0},
        '{8'h40, 8'h80, 1'b1, 1'b0, 8'h02, 1'b1}, '{8'h40, 8'h80, 1'b0, 1'b1, 8'h02, 1'b0},
        '{8'h80, 8'h80, 1'b0, 1'b1, 8'h01, 1'b1}, '{8'hC0, 8'h00, 1'b1, 1'b1, 8'h00, 1'b0}};
    always #10 clk_sys = ~clk_sys;
    mims_host_model i_mims_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata));
    mims_top i_mims_top (.clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata), .status_live(status_live),
        .chan_mode(chan_mode), .vid_line_three_irq(vid_line_three_irq), .vid_line_four_irq(vid_line_four_irq),
        .cfg(cfg), .ext_irq_event(ext_irq_event), .reinit_pulse(reinit_pulse));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp1(input string name, input logic exp, input logic got);
        cmp8(name, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        cmp8("cfg in reset", 8'h00, {5'h00, cfg});
        srst = 1'b0;
        foreach (rows[i]) begin
            chan_mode = rows[i].mode;
            vid_line_three_irq = rows[i].v3;
            vid_line_four_irq = rows[i].v4;
            i_mims_host_model.access(1'b1, 8'h44, rows[i].mask, rd_val);
            repeat (3) @(negedge clk_sys);
            cmp8("cfg", rows[i].cfg, {5'h00, cfg});
            cmp1("ext_irq_event", rows[i].irq, ext_irq_event);
        end
        // Reserved bits 4-5 never stick
        i_mims_host_model.access(1'b1, 8'h44, 8'hFF, rd_val);
        i_mims_host_model.access(1'b0, 8'h44, 8'h00, rd_val);
        cmp8("mask readback", 8'hCF, rd_val);
        // Once bit stays set through a later write that clears it
        i_mims_host_model.access(1'b1, 8'h44, 8'h08, rd_val);
        i_mims_host_model.access(1'b0, 8'h44, 8'h00, rd_val);
        cmp8("once bit held", 8'h0C, rd_val);
        i_mims_host_model.access(1'b1, 8'h40, 8'h80, rd_val);
        cmp1("reinit_pulse", 1'b1, reinit_pulse);
        @(negedge clk_sys);
        cmp1("reinit_pulse gone", 1'b0, reinit_pulse);
        i_mims_host_model.access(1'b0, 8'h44, 8'h00, rd_val);
        cmp8("mask after reinit", 8'h00, rd_val);
        cmp8("cfg after reinit", 8'h00, {5'h00, cfg});
        status_live = 8'h03;
        repeat (3) @(negedge clk_sys);
        i_mims_host_model.access(1'b0, 8'h4C, 8'h00, rd_val);
        cmp8("mirror", 8'h03, rd_val);
        i_mims_host_model.access(1'b1, 8'h4C, 8'hFF, rd_val);
        i_mims_host_model.access(1'b0, 8'h4C, 8'h00, rd_val);
        cmp8("mirror kept", 8'h03, rd_val);
        i_mims_host_model.access(1'b0, 8'h44, 8'h00, rd_val);
        cmp8("mask after mirror write", 8'h00, rd_val);
        status_live = 8'h02;
        i_mims_host_model.access(1'b0, 8'h4C, 8'h00, rd_val);
        cmp8("mirror follows", 8'h02, rd_val);
        i_mims_host_model.access(1'b0, 8'h7E, 8'h00, rd_val);
        cmp8("unmapped read", 8'h00, rd_val);
        // Reset in mid-run drops every setting, as at power-on
        chan_mode = 8'h80;
        vid_line_three_irq = 1'b1;
        i_mims_host_model.access(1'b1, 8'h44, 8'hC8, rd_val);
        repeat (2) @(negedge clk_sys);
        cmp1("irq before reset", 1'b1, ext_irq_event);
        cmp8("cfg before reset", 8'h07, {5'h00, cfg});
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        cmp8("cfg in mid reset", 8'h00, {5'h00, cfg});
        cmp1("irq in mid reset", 1'b0, ext_irq_event);
        srst = 1'b0;
        i_mims_host_model.access(1'b0, 8'h44, 8'h00, rd_val);
        cmp8("mask after reset", 8'h00, rd_val);
        cmp1("irq after reset", 1'b0, ext_irq_event);
        report_and_stop();
    end
endmodule
